// ===== verilog/eoc_pkg.sv
// Package with register map, field layout, mode codes and timing for the oscillator control block
package eoc_pkg;
  // Special-function register decode
  localparam logic [7:0] EOC_CTL_ADDR = 8'h9f;
  localparam logic [7:0] EOC_CTL_PAGE = 8'h0f;
  localparam logic [7:0] EOC_CTL_RESET = 8'h00;
  // Field positions
  localparam int EOC_VALID_BIT = 7;
  localparam int EOC_MODE_MSB = 6;
  localparam int EOC_MODE_LSB = 4;
  localparam int EOC_UNUSED_BIT = 3;
  localparam int EOC_DRIVE_MSB = 2;
  localparam int EOC_DRIVE_LSB = 0;
  localparam logic [7:0] EOC_WRITE_MASK = 8'h77;
  // Mode select encodings
  typedef enum logic [2:0] {
    EOC_MODE_OFF = 3'h0,
    EOC_MODE_RSVD = 3'h1,
    EOC_MODE_CMOS = 3'h2,
    EOC_MODE_CMOS_DIV2 = 3'h3,
    EOC_MODE_RC = 3'h4,
    EOC_MODE_CAP = 3'h5,
    EOC_MODE_XTAL = 3'h6,
    EOC_MODE_XTAL_DIV2 = 3'h7
  } eoc_mode_t;
  localparam logic [2:0] EOC_DRIVE_RESET = 3'h0;
  // Count of stable-detector samples before the crystal is declared valid
  localparam int EOC_STABLE_CYCLES = 16;
  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] page;
    logic [7:0] wdata;
  } eoc_sfr_req_t;
  // Drive settings handed to the analog oscillator
  typedef struct packed {
    logic enable;
    logic [2:0] mode;
    logic [2:0] drive;
    logic use_in_pin;
    logic use_out_pin;
  } eoc_osc_ctl_t;
endpackage

// ===== verilog/eoc_sync.sv
// Two-flop synchroniser for the asynchronous amplitude detector level
`timescale 1ns/1ps
module eoc_sync
  import eoc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level in and synchronised level out
  input wire logic din,
  output logic dout
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  // Next values simply shift the level along
  always_comb
  begin
    meta_next = din;
    sync_next = meta_reg;
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign dout = sync_reg;
endmodule

// ===== verilog/eoc_ctl.sv
// External oscillator control register, crystal valid tracking and pin ownership
`timescale 1ns/1ps
module eoc_ctl
  import eoc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Special-function register bus
  input wire eoc_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_sel,
  // Amplitude detector from the analog oscillator, asynchronous
  input wire logic osc_amp_ok,
  // Controls to the analog oscillator and the port pins
  output eoc_osc_ctl_t osc_ctl,
  output logic crystal_valid_flag
);
  typedef enum logic [2:0] {
    EOC_ST_IDLE = 3'b001,
    EOC_ST_SETTLE = 3'b010,
    EOC_ST_VALID = 3'b100
  } eoc_state_t;

  logic [2:0] mode_reg;
  logic [2:0] mode_next;
  logic [2:0] drive_reg;
  logic [2:0] drive_next;
  eoc_state_t state_reg;
  eoc_state_t state_next;
  logic [4:0] stab_cnt_reg;
  logic [4:0] stab_cnt_next;
  logic amp_ok_sync;
  logic hit;
  logic xtal_mode;
  eoc_osc_ctl_t osc_ctl_next;
  logic valid_reg;
  logic valid_next;
  logic [7:0] image_reg;
  logic [7:0] image_next;

  // Crystal modes are the codes beginning with binary 11
  function automatic logic is_xtal(input logic [2:0] m);
    is_xtal = (m[2:1] == 2'b11);
  endfunction

  // Amplitude detector comes from the analog domain
  eoc_sync u_amp_sync (
    .clk(clk),
    .rst(rst),
    .din(osc_amp_ok),
    .dout(amp_ok_sync)
  );

  // Address and page decode
  assign hit = (sfr_req.addr == EOC_CTL_ADDR) && (sfr_req.page == EOC_CTL_PAGE);
  assign sfr_sel = hit;
  assign xtal_mode = is_xtal(mode_reg);

  // Writable fields; bit 7 and bit 3 never stored
  always_comb
  begin
    mode_next = mode_reg;
    drive_next = drive_reg;
    if (sfr_req.wr && hit)
    begin
      mode_next = sfr_req.wdata[EOC_MODE_MSB:EOC_MODE_LSB];
      drive_next = sfr_req.wdata[EOC_DRIVE_MSB:EOC_DRIVE_LSB];
    end
  end

  // Crystal stability tracking; any mode change restarts settling
  always_comb
  begin
    state_next = state_reg;
    stab_cnt_next = stab_cnt_reg;
    case (state_reg)
      EOC_ST_IDLE:
      begin
        stab_cnt_next = 5'h00;
        if (xtal_mode)
          state_next = EOC_ST_SETTLE;
      end
      EOC_ST_SETTLE:
      begin
        if (!xtal_mode)
          state_next = EOC_ST_IDLE;
        else if (!amp_ok_sync)
          stab_cnt_next = 5'h00;
        else if (stab_cnt_reg == 5'(EOC_STABLE_CYCLES - 1))
          state_next = EOC_ST_VALID;
        else
          stab_cnt_next = stab_cnt_reg + 5'h01;
      end
      EOC_ST_VALID:
      begin
        // Losing amplitude drops the flag; safer than a stale valid
        if (!xtal_mode || !amp_ok_sync)
          state_next = EOC_ST_IDLE;
      end
      default:
        state_next = EOC_ST_IDLE;
    endcase
    if (mode_next != mode_reg)
      state_next = EOC_ST_IDLE;
  end

  // Oscillator and pin controls, registered so they never glitch
  always_comb
  begin
    osc_ctl_next.enable = (mode_reg != EOC_MODE_OFF) && (mode_reg != EOC_MODE_RSVD);
    osc_ctl_next.mode = mode_reg;
    osc_ctl_next.drive = drive_reg;
    osc_ctl_next.use_in_pin = xtal_mode;
    osc_ctl_next.use_out_pin = osc_ctl_next.enable;
  end

  // Valid flag and read image come from next values, so both registers
  // change on the same edge as the mode and state they describe
  always_comb
  begin
    valid_next = (state_next == EOC_ST_VALID) && is_xtal(mode_next);
    image_next = 8'h00;
    image_next[EOC_VALID_BIT] = valid_next;
    image_next[EOC_MODE_MSB:EOC_MODE_LSB] = mode_next;
    image_next[EOC_UNUSED_BIT] = 1'b0;
    image_next[EOC_DRIVE_MSB:EOC_DRIVE_LSB] = drive_next;
  end

  // Register fields; reset leaves the oscillator circuit off
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_reg <= EOC_CTL_RESET[EOC_MODE_MSB:EOC_MODE_LSB];
      drive_reg <= EOC_CTL_RESET[EOC_DRIVE_MSB:EOC_DRIVE_LSB];
    end
    else
    begin
      mode_reg <= mode_next;
      drive_reg <= drive_next;
    end
  end

  // Stability tracker; the count clears with the state so a reset
  // in mid-settle can never leave a partial count behind
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= EOC_ST_IDLE;
      stab_cnt_reg <= 5'h00;
    end
    else
    begin
      state_reg <= state_next;
      stab_cnt_reg <= stab_cnt_next;
    end
  end

  // Oscillator and pin controls; one cycle behind the register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      osc_ctl <= '0;
    end
    else
    begin
      osc_ctl <= osc_ctl_next;
    end
  end

  // Valid flag and read image flops
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      valid_reg <= EOC_CTL_RESET[EOC_VALID_BIT];
      image_reg <= EOC_CTL_RESET;
    end
    else
    begin
      valid_reg <= valid_next;
      image_reg <= image_next;
    end
  end

  assign crystal_valid_flag = valid_reg;

  // Read data: a flop image gated by the decode
  // Zero when unaddressed, so the core may OR all register sources together
  always_comb
  begin
    sfr_rdata = 8'h00;
    if (hit)
      sfr_rdata = image_reg;
  end
endmodule

// ===== bench/eoc_ctl_properties.sv
// Port assertions for the oscillator control block
`timescale 1ns/1ps
module eoc_ctl_properties
  import eoc_pkg::*;
(
  // Observed ports
  input wire logic clk,
  input wire logic rst,
  input wire eoc_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_sel,
  input wire logic osc_amp_ok,
  input wire eoc_osc_ctl_t osc_ctl,
  input wire logic crystal_valid_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_sel_decode: assert property (sfr_sel == (sfr_req.addr == 8'h9f && sfr_req.page == 8'h0f))
    else $error("decode");
  chk_unused_bit: assert property (sfr_sel |-> !sfr_rdata[3])
    else $error("bit 3");
  chk_valid_read: assert property (sfr_sel |-> sfr_rdata[7] == crystal_valid_flag)
    else $error("valid read");
  chk_valid_mode: assert property (crystal_valid_flag |-> osc_ctl.mode[2:1] == 2'b11)
    else $error("valid mode");
  chk_write_land: assert property (sfr_req.wr && sfr_sel |-> ##2 osc_ctl.mode == $past(sfr_req.wdata[6:4], 2)
    && osc_ctl.drive == $past(sfr_req.wdata[2:0], 2)) else $error("write");
  chk_pin_owner: assert property (osc_ctl.enable == (osc_ctl.mode > 3'h1) && osc_ctl.use_out_pin == osc_ctl.enable
    && osc_ctl.use_in_pin == (osc_ctl.mode[2:1] == 2'b11)) else $error("pins");
  chk_amp_drop: assert property (!osc_amp_ok [*4] |-> !crystal_valid_flag)
    else $error("drop");
  chk_settle_min: assert property ($rose(crystal_valid_flag) |-> $past(osc_amp_ok, 16))
    else $error("settle");
endmodule
bind eoc_ctl eoc_ctl_properties i_props (.clk, .rst, .sfr_req, .sfr_rdata, .sfr_sel, .osc_amp_ok, .osc_ctl,
  .crystal_valid_flag);

// ===== bench/eoc_xtal_model.sv
// Behavioural crystal: amplitude builds only while both pins are driven
`timescale 1ns/1ps
module eoc_xtal_model
  import eoc_pkg::*;
#(
  parameter int START = 40
)
(
  // Clock, reset and drive
  input wire logic clk,
  input wire logic rst,
  input wire eoc_osc_ctl_t osc_ctl,
  input wire logic kill,
  // Amplitude detector level
  output logic osc_amp_ok
);
  int cnt;
  // Kill models a crystal that stops swinging
  always @(posedge clk or posedge rst)
    if (rst || kill || !(osc_ctl.use_in_pin && osc_ctl.use_out_pin))
      cnt <= 0;
    else if (cnt < START)
      cnt <= cnt + 1;
  assign osc_amp_ok = (cnt == START);
endmodule

// ===== bench/eoc_ctl_tb.sv
// Self-checking bench for the oscillator control register
`timescale 1ns/1ps
module eoc_ctl_tb;
  import eoc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic kill = 1'b0;
  logic osc_amp_ok, sfr_sel, crystal_valid_flag;
  logic [7:0] sfr_rdata;
  eoc_sfr_req_t sfr_req = '0;
  eoc_osc_ctl_t osc_ctl;
  int fails = 0, n_tests = 0, i, k;
  localparam int SETTLE_CYCLES = 40000; // 1 ms of 25 ns cycles
  eoc_ctl i_eoc_ctl (.clk(clk), .rst(rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_sel(sfr_sel),
    .osc_amp_ok(osc_amp_ok), .osc_ctl(osc_ctl), .crystal_valid_flag(crystal_valid_flag));
  eoc_xtal_model i_eoc_xtal_model (.clk(clk), .rst(rst), .osc_ctl(osc_ctl), .kill(kill), .osc_amp_ok(osc_amp_ok));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One-cycle write strobe; reads are combinational on the address
  task automatic wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
    @(posedge clk);
    sfr_req <= '{1'b1, 1'b0, a, p, d};
    @(posedge clk);
    sfr_req <= '0;
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] exp);
    @(posedge clk);
    sfr_req <= '{1'b0, 1'b1, 8'h9f, p, 8'h00};
    @(negedge clk);
    chk(sfr_rdata, exp);
  endtask
  // Software poll of the valid bit through the register, under a bound
  task automatic poll_valid(input logic v);
    logic seen;
    seen = ~v;
    for (k = 0; k < 200 && seen !== v; k++)
    begin
      @(posedge clk);
      sfr_req <= '{1'b0, 1'b1, 8'h9f, 8'h0f, 8'h00};
      @(negedge clk);
      seen = sfr_rdata[7];
    end
    if (seen !== v)
    begin
      fails++;
      close_out();
    end
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(8'h0f, 8'h00);
    chk({1'b0, osc_ctl.mode, 1'b0, osc_ctl.drive}, 8'h00);
    wr(8'h9f, 8'h0f, 8'hff);
    rd(8'h0f, 8'h77);
    wr(8'h9e, 8'h0f, 8'h12);
    wr(8'h9f, 8'h0e, 8'h12);
    rd(8'h0f, 8'h77);
    rd(8'h0e, 8'h00);
    $display("access test done");
    for (i = 0; i < 8; i++)
    begin
      wr(8'h9f, 8'h0f, {1'b0, 3'(i), 1'b0, 3'(7 - i)});
      rd(8'h0f, {1'b0, 3'(i), 1'b0, 3'(7 - i)});
      chk({7'h0, osc_ctl.enable}, {7'h0, i > 1});
      chk({7'h0, osc_ctl.use_in_pin}, {7'h0, i > 5});
      chk({7'h0, osc_ctl.use_out_pin}, {7'h0, i > 1});
      chk({1'b0, osc_ctl.mode, 1'b0, osc_ctl.drive}, {1'b0, 3'(i), 1'b0, 3'(7 - i)});
    end
    $display("mode test done");
    wr(8'h9f, 8'h0f, 8'h61);
    rd(8'h0f, 8'h61);
    repeat (SETTLE_CYCLES) @(posedge clk);
    poll_valid(1'b1);
    rd(8'h0f, 8'he1);
    chk({7'h0, crystal_valid_flag}, 8'h01);
    wr(8'h9f, 8'h0f, 8'h60);
    rd(8'h0f, 8'he0);
    @(posedge clk);
    kill <= 1'b1;
    poll_valid(1'b0);
    rd(8'h0f, 8'h60);
    @(posedge clk);
    kill <= 1'b0;
    poll_valid(1'b1);
    $display("crystal test done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(8'h0f, 8'h00);
    chk({7'h0, osc_ctl.enable}, 8'h00);
    wr(8'h9f, 8'h0f, 8'h57);
    rd(8'h0f, 8'h57);
    $display("reset test done");
    close_out();
  end
endmodule
